//--- include/sodel_consts.svh
`ifndef SODEL_CONSTS_SVH
`define SODEL_CONSTS_SVH
// Register byte offsets
`define SODEL_ADR_CTRL 8'h00
`define SODEL_ADR_STAT 8'h04
`define SODEL_ADR_IRQ 8'h08
`define SODEL_ADR_MASK 8'h0C
`define SODEL_ADR_OFFDLY 8'h10
`define SODEL_ADR_ENTMO 8'h14
// Control bit positions
`define SODEL_CTL_JOG_SEC 0
`define SODEL_CTL_CFG_MODE 1
`define SODEL_CTL_MANUAL 2
`define SODEL_CTL_LOCKOUT 3
`define SODEL_CTL_INIT 4
// Event bit positions
`define SODEL_EV_OFFDLY 0
`define SODEL_EV_CANCEL 1
`define SODEL_EV_ENTMO 2
`define SODEL_EV_ENSTOP 3
`define SODEL_EV_W 4
// Timing
`define SODEL_CLK_HZ 40000000
`define SODEL_TICK_HZ 1000
`define SODEL_TICK_DIV (`SODEL_CLK_HZ / `SODEL_TICK_HZ)
`define SODEL_LAMP_MS 500
`define SODEL_FLASH_MS 250
`define SODEL_OFFDLY_RST 32'h0000_03E8
`define SODEL_ENTMO_RST 32'h0000_2710
`endif

//--- include/sodel_pkg.sv
package sodel_pkg;
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [7:0] adr;
      logic [31:0] dat;
   } sodel_wb_req_type;
   typedef struct packed {
      logic green;
      logic red;
   } sodel_led_type;
   typedef struct packed {
      logic guard_run;
      logic cancel_dly;
      logic latch_reset;
      logic enable_run;
      logic jog_run;
      logic usb_present;
      logic config_backup_module;
   } sodel_in_type;
   typedef enum logic [1:0] {
      SODEL_LAMP_GREEN,
      SODEL_LAMP_RED,
      SODEL_LAMP_DARK,
      SODEL_LAMP_RUN
   } sodel_lamp_type;
endpackage

//--- rtl/sodel_timer.sv
// Tick-driven down counter with terminal count
module sodel_timer #(
   parameter int W = 32
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic ce,
   input wire logic tick,
   input wire logic start,
   input wire logic stop,
   input wire logic [W-1:0] limit,
   output logic running,
   output logic expired
);
   typedef struct packed {
      logic run;
      logic exp;
      logic [W-1:0] cnt;
   } sodel_tmr_type;
   sodel_tmr_type q, d;
   always_comb begin
      d = q;
      d.exp = 1'b0;
      if (stop) begin
         d.run = 1'b0;
      end else if (start) begin
         d.run = 1'b1;
         d.cnt = limit;
      end else if (q.run && tick) begin
         if (q.cnt <= W'(1)) begin
            d.run = 1'b0;
            d.exp = 1'b1;
         end else begin
            d.cnt = q.cnt - W'(1);
         end
      end
   end
   always_ff @(posedge mclk) begin
      if (srst) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end
   assign running = q.run;
   assign expired = q.exp;
endmodule // sodel_timer

//--- rtl/sodel_top.sv
// Contract
// - Cancel-delay input turns a delaying output off at once.
// - Guard returning to run during off-delay keeps output on.
// - Latch reset during off-delay is ignored; output ends off.
// - Enabling device held in run past its limit turns output off.
// - After timeout, only stop then run re-enables the output.
// - Enabling device stop turns off all its outputs.
// - Reset while enabling stopped hands control to associated inputs.
// - With jog on primary, either stop turns the primary off.
// - With jog on secondary, primary follows enabling device alone.
// - Secondary is on only while enabling and jog both run.
// - Power-up lamps: green 0.5 s, red 0.5 s, dark 0.5 s; dark in init.
// - Otherwise every status lamp is lit.
// - Power lamp flashes green in config/manual, red in lockout.
// - Config-port lamp solid green with USB or backup module present.
//
// Register access over Wishbone and the placing of the registers are this design's own decisions.
module sodel_top
   import sodel_pkg::*;
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic ce,
   input sodel_pkg::sodel_in_type pins,
   input sodel_pkg::sodel_wb_req_type wb_req,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic out_delayed,
   output logic out_primary,
   output logic out_secondary,
   output sodel_pkg::sodel_led_type led_power,
   output sodel_pkg::sodel_led_type led_config,
   output logic irq
);
   import sodel_pkg::*;
`include "sodel_consts.svh"

   // Overridable so a bench can shorten the tick and lamp phases
   parameter int TDIV = `SODEL_TICK_DIV;
   parameter int LAMP = `SODEL_LAMP_MS;
   parameter int FLASH = `SODEL_FLASH_MS;

   typedef struct packed {
      logic [31:0] dat;
      logic ack;
      logic [4:0] ctrl;
      logic [`SODEL_EV_W-1:0] stat;
      logic [`SODEL_EV_W-1:0] mask;
      logic [31:0] offdly_lim;
      logic [31:0] entmo_lim;
      logic [15:0] div;
      logic tick;
      sodel_lamp_type lamp;
      logic [15:0] lamp_cnt;
      logic [15:0] flash_cnt;
      logic flash;
      logic dly_on;
      logic en_locked;
      logic en_prev;
      logic handover;
      logic [2:0] outs;
      sodel_led_type pwr;
      sodel_led_type cfg;
      logic irq;
   } sodel_state_type;

   sodel_state_type q, d;
   logic od_start, od_stop, od_run, od_exp;
   logic en_start, en_stop, en_run, en_exp;
   logic wr, rd_hit;
   logic [`SODEL_EV_W-1:0] ev;

   // Off-delay timer
   assign od_start = q.dly_on && !pins.guard_run && !od_run;
   assign od_stop = pins.guard_run || pins.cancel_dly;
   sodel_timer #(.W(32)) u_offdly (
      .mclk(mclk),
      .srst(srst),
      .ce(ce),
      .tick(q.tick),
      .start(od_start),
      .stop(od_stop),
      .limit(q.offdly_lim),
      .running(od_run),
      .expired(od_exp)
   );

   // Enabling-device run-time limit
   assign en_start = pins.enable_run && !q.en_prev;
   assign en_stop = !pins.enable_run;
   sodel_timer #(.W(32)) u_entmo (
      .mclk(mclk),
      .srst(srst),
      .ce(ce),
      .tick(q.tick),
      .start(en_start),
      .stop(en_stop),
      .limit(q.entmo_lim),
      .running(en_run),
      .expired(en_exp)
   );

   assign wr = wb_req.cyc && wb_req.stb && wb_req.we && !q.ack;
   assign rd_hit = wb_req.cyc && wb_req.stb && !q.ack;

   always_comb begin
      d = q;
      ev = '0;
      d.ack = rd_hit;
      // Fixed-rate tick
      d.tick = 1'b0;
      if (q.div == 16'(TDIV - 1)) begin
         d.div = '0;
         d.tick = 1'b1;
      end else begin
         d.div = q.div + 16'h0001;
      end

      // Delayed output: on with guard, held through delay
      if (pins.guard_run && !od_run) begin
         d.dly_on = 1'b1;
      end else if (pins.cancel_dly && !pins.guard_run) begin
         d.dly_on = 1'b0;
         ev[`SODEL_EV_CANCEL] = q.dly_on;
      end else if (od_exp) begin
         d.dly_on = 1'b0;
         ev[`SODEL_EV_OFFDLY] = 1'b1;
      end
      // Latch reset not looked at while delaying

      // Enabling device lock-out and re-arm
      d.en_prev = pins.enable_run;
      if (en_exp) begin
         d.en_locked = 1'b1;
         ev[`SODEL_EV_ENTMO] = 1'b1;
      end else if (!pins.enable_run) begin
         d.en_locked = 1'b0;
      end
      if (q.en_prev && !pins.enable_run) begin
         ev[`SODEL_EV_ENSTOP] = 1'b1;
      end

      // Authority stays with guard inputs until the device runs or stops anew
      if (!pins.enable_run && pins.latch_reset) begin
         d.handover = 1'b1;
      end else if (pins.enable_run || q.en_prev) begin
         d.handover = 1'b0;
      end
      // Primary and secondary outputs
      if (!pins.enable_run) begin
         d.outs[0] = d.handover && pins.guard_run;
      end else if (q.ctrl[`SODEL_CTL_JOG_SEC]) begin
         d.outs[0] = !q.en_locked && !en_exp && pins.guard_run;
      end else begin
         d.outs[0] = !q.en_locked && !en_exp && pins.guard_run && pins.jog_run;
      end
      d.outs[1] = q.ctrl[`SODEL_CTL_JOG_SEC] && pins.enable_run && pins.jog_run
         && !q.en_locked && !en_exp;
      d.outs[2] = d.dly_on;

      // Lamps
      if (q.tick) begin
         if (q.flash_cnt == 16'(FLASH - 1)) begin
            d.flash_cnt = '0;
            d.flash = !q.flash;
         end else begin
            d.flash_cnt = q.flash_cnt + 16'h0001;
         end
      end
      if (q.tick && q.lamp != SODEL_LAMP_RUN) begin
         if (q.lamp_cnt == 16'(LAMP - 1)) begin
            d.lamp_cnt = '0;
            unique case (q.lamp)
               SODEL_LAMP_GREEN: d.lamp = SODEL_LAMP_RED;
               SODEL_LAMP_RED: d.lamp = SODEL_LAMP_DARK;
               SODEL_LAMP_DARK: d.lamp = SODEL_LAMP_RUN;
               SODEL_LAMP_RUN: d.lamp = SODEL_LAMP_RUN;
            endcase
         end else begin
            d.lamp_cnt = q.lamp_cnt + 16'h0001;
         end
      end
      unique case (q.lamp)
         SODEL_LAMP_GREEN: begin
            d.pwr = '{green: 1'b1, red: 1'b0};
            d.cfg = '{green: 1'b1, red: 1'b0};
         end
         SODEL_LAMP_RED: begin
            d.pwr = '{green: 1'b0, red: 1'b1};
            d.cfg = '{green: 1'b0, red: 1'b1};
         end
         SODEL_LAMP_DARK: begin
            d.pwr = '0;
            d.cfg = '0;
         end
         SODEL_LAMP_RUN: begin
            if (q.ctrl[`SODEL_CTL_INIT]) begin
               d.pwr = '0;
               d.cfg = '0;
            end else begin
               if (q.ctrl[`SODEL_CTL_LOCKOUT]) begin
                  d.pwr = '{green: 1'b0, red: q.flash};
               end else if (q.ctrl[`SODEL_CTL_CFG_MODE] || q.ctrl[`SODEL_CTL_MANUAL]) begin
                  d.pwr = '{green: q.flash, red: 1'b0};
               end else begin
                  d.pwr = '{green: 1'b1, red: 1'b0};
               end
               if (pins.usb_present || pins.config_backup_module) begin
                  d.cfg = '{green: 1'b1, red: 1'b0};
               end else begin
                  d.cfg = '{green: 1'b0, red: 1'b1};
               end
            end
         end
      endcase

      // Register writes; hardware set wins over clear
      d.stat = q.stat & ~(wr && wb_req.adr == `SODEL_ADR_IRQ && wb_req.sel[0]
         ? wb_req.dat[`SODEL_EV_W-1:0] : '0);
      d.stat = d.stat | ev;
      if (wr && wb_req.sel[0]) begin
         unique case (wb_req.adr)
            `SODEL_ADR_CTRL: d.ctrl = wb_req.dat[4:0];
            `SODEL_ADR_MASK: d.mask = wb_req.dat[`SODEL_EV_W-1:0];
            default: ;
         endcase
      end
      if (wr && wb_req.sel == 4'hF) begin
         unique case (wb_req.adr)
            `SODEL_ADR_OFFDLY: d.offdly_lim = wb_req.dat;
            `SODEL_ADR_ENTMO: d.entmo_lim = wb_req.dat;
            default: ;
         endcase
      end
      unique case (wb_req.adr)
         `SODEL_ADR_CTRL: d.dat = {27'h0, q.ctrl};
         `SODEL_ADR_STAT: d.dat = {25'h0, q.outs, q.en_locked, od_run, en_run, q.dly_on};
         `SODEL_ADR_IRQ: d.dat = {28'h0, q.stat};
         `SODEL_ADR_MASK: d.dat = {28'h0, q.mask};
         `SODEL_ADR_OFFDLY: d.dat = q.offdly_lim;
         `SODEL_ADR_ENTMO: d.dat = q.entmo_lim;
         default: d.dat = 32'h0000_0000;
      endcase
      d.irq = |(d.stat & q.mask);
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         q <= '0;
         q.lamp <= SODEL_LAMP_GREEN;
         q.offdly_lim <= `SODEL_OFFDLY_RST;
         q.entmo_lim <= `SODEL_ENTMO_RST;
         q.pwr <= '{green: 1'b1, red: 1'b0};
         q.cfg <= '{green: 1'b1, red: 1'b0};
      end else if (ce) begin
         q <= d;
      end
   end

   assign wb_dat_o = q.dat;
   assign wb_ack_o = q.ack;
   assign out_primary = q.outs[0];
   assign out_secondary = q.outs[1];
   assign out_delayed = q.outs[2];
   assign led_power = q.pwr;
   assign led_config = q.cfg;
   assign irq = q.irq;
endmodule // sodel_top

//--- test/sodel_field.sv
// Safety input devices and operator switches
module sodel_field
   import sodel_pkg::*;
(
   input wire logic mclk,
   output sodel_pkg::sodel_in_type pins
);
   timeunit 1ns;
   timeprecision 1ps;
   initial pins = '0;
   task put(input sodel_in_type v);
      @(posedge mclk);
      pins <= v;
   endtask
   // Operator takes enabling device to stop, then back to run
   task cycle_enable(input sodel_in_type v);
      sodel_in_type s;
      s = v;
      s.enable_run = 1'h0;
      put(s);
      put(v);
   endtask
endmodule // sodel_field

//--- test/sodel_top_monitor.sv
module sodel_top_monitor
   import sodel_pkg::*;
(
   input wire logic mclk,
   input wire logic srst,
   input sodel_pkg::sodel_in_type pins,
   input sodel_pkg::sodel_wb_req_type wb_req,
   input wire logic wb_ack_o,
   input wire logic out_delayed,
   input wire logic out_primary,
   input wire logic out_secondary,
   input sodel_pkg::sodel_led_type led_power
);
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held too long");
   chk_ack_answer: assert property (wb_req.cyc && wb_req.stb && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   chk_cancel_off: assert property (pins.cancel_dly && !pins.guard_run |=> !out_delayed)
      else $error("cancel did not switch off");
   chk_guard_keeps: assert property (pins.guard_run && out_delayed |=> out_delayed)
      else $error("delayed output dropped in run");
   chk_delay_holds: assert property ($fell(pins.guard_run) && out_delayed && !pins.cancel_dly
      |=> out_delayed [*8])
      else $error("delayed output fell early");
   chk_enable_stop: assert property ($fell(pins.enable_run) && !pins.latch_reset
      |=> !out_primary && !out_secondary)
      else $error("enable stop left an output on");
   chk_handover: assert property (!pins.enable_run && pins.latch_reset
      |=> out_primary == $past(pins.guard_run))
      else $error("reset did not hand over control");
   chk_sec_needs: assert property (!(pins.enable_run && pins.jog_run) |=> !out_secondary)
      else $error("secondary on without both");
   chk_lamp_green: assert property ($fell(srst) |-> (led_power.green && !led_power.red) [*8])
      else $error("power-up lamp not green");
endmodule // sodel_top_monitor
bind sodel_top sodel_top_monitor i_mon (.mclk(mclk), .srst(srst), .pins(pins),
   .wb_req(wb_req), .wb_ack_o(wb_ack_o), .out_delayed(out_delayed),
   .out_primary(out_primary), .out_secondary(out_secondary), .led_power(led_power));

//--- test/test_sodel_top.sv
`include "sodel_consts.svh"
module test_sodel_top;
   import sodel_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'h0;
   logic srst = 1'h1;
   logic ce = 1'h1;
   logic [3:0] wsel = 4'hF;
   logic [3:0] seen;
   sodel_wb_req_type wb_req = '0;
   sodel_in_type pins;
   logic [31:0] wb_dat_o;
   logic [31:0] rd;
   logic wb_ack_o, out_delayed, out_primary, out_secondary, irq;
   sodel_led_type led_power, led_config;
   int fails = 0;
   int checked = 0;
   int n;
   always #12.5 mclk = ~mclk;
   sodel_field i_field (.mclk(mclk), .pins(pins));
   sodel_top #(.TDIV(4), .LAMP(4), .FLASH(2)) i_dut (.mclk(mclk), .srst(srst), .ce(ce),
      .pins(pins), .wb_req(wb_req),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .out_delayed(out_delayed),
      .out_primary(out_primary), .out_secondary(out_secondary), .led_power(led_power),
      .led_config(led_config), .irq(irq));
   task chk1(input logic got, input logic exp, input string m);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t %s", $time, m);
      end
   endtask
   task chk32(input logic [31:0] got, input logic [31:0] exp, input string m);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t %s", $time, m);
      end
   endtask
   task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge mclk);
      wb_req <= '{1'h1, 1'h1, we, wsel, a, d};
      k = 0;
      do begin
         @(negedge mclk);
         k++;
      end while (wb_ack_o !== 1'h1 && k < 50);
      rd = wb_dat_o;
      chk1(wb_ack_o, 1'h1, "no ack");
      // Release only after the edge that samples ack high
      @(posedge mclk);
      wb_req <= '0;
   endtask
   task settle;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
   endtask
   task watch;
      seen = '0;
      repeat (40) begin
         @(negedge mclk);
         seen |= {led_power.green, !led_power.green, led_power.red, !led_power.red};
      end
   endtask
   task t_lamps;
      wb(1'h1, `SODEL_ADR_CTRL, 32'h0);
      i_field.put(7'h00);
      settle;
      chk1(led_config.red, 1'h1, "config lamp red");
      chk1(led_power.green, 1'h1, "power lamp green");
      i_field.put(7'h02);
      settle;
      chk1(led_config.green, 1'h1, "usb lamp");
      i_field.put(7'h01);
      settle;
      chk1(led_config.green, 1'h1, "backup lamp");
      wb(1'h1, `SODEL_ADR_CTRL, 32'h2);
      watch;
      chk32({28'h0, seen}, 32'hD, "config mode flash");
      wb(1'h1, `SODEL_ADR_CTRL, 32'h4);
      watch;
      chk32({28'h0, seen}, 32'hD, "manual flash");
      wb(1'h1, `SODEL_ADR_CTRL, 32'h8);
      watch;
      chk32({28'h0, seen}, 32'h7, "lockout flash");
      wb(1'h1, `SODEL_ADR_CTRL, 32'h10);
      watch;
      chk32({28'h0, seen}, 32'h5, "init dark");
      chk1(led_config.green | led_config.red, 1'h0, "init config dark");
      wb(1'h1, `SODEL_ADR_CTRL, 32'h1);
      $display("test lamps done");
   endtask
   task t_freeze;
      @(posedge mclk);
      ce <= 1'h0;
      i_field.put(7'h00);
      settle;
      chk1(out_delayed, 1'h1, "frozen state");
      @(posedge mclk);
      ce <= 1'h1;
      i_field.put(7'h40);
      settle;
      chk1(out_delayed, 1'h1, "guard back after freeze");
      $display("test freeze done");
   endtask
   task summarize;
      $display("counts: %0d checked, %0d failed", checked, fails);
      if (fails == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task t_regs;
      @(negedge mclk);
      chk1(led_power.green, 1'h1, "lamp green");
      chk1(out_delayed | out_primary | irq, 1'h0, "outputs after reset");
      wb(1'h0, `SODEL_ADR_OFFDLY, 32'h0);
      chk32(rd, `SODEL_OFFDLY_RST, "offdly reset");
      wb(1'h0, `SODEL_ADR_ENTMO, 32'h0);
      chk32(rd, `SODEL_ENTMO_RST, "entmo reset");
      wb(1'h1, `SODEL_ADR_OFFDLY, 32'h14);
      wb(1'h1, `SODEL_ADR_ENTMO, 32'h3C);
      wsel = 4'h1;
      wb(1'h1, `SODEL_ADR_OFFDLY, 32'h5);
      wsel = 4'hF;
      wb(1'h0, `SODEL_ADR_OFFDLY, 32'h0);
      chk32(rd, 32'h14, "partial limit write");
      wb(1'h0, 8'h40, 32'h0);
      chk32(rd, 32'h0, "unmapped read");
      $display("test regs done");
   endtask
   task t_jog_pri;
      wb(1'h1, `SODEL_ADR_CTRL, 32'h0);
      i_field.put(7'h4C);
      settle;
      chk1(out_primary, 1'h1, "primary on");
      i_field.put(7'h48);
      settle;
      chk1(out_primary, 1'h0, "jog stop");
      i_field.put(7'h4C);
      settle;
      i_field.put(7'h44);
      settle;
      chk1(out_primary, 1'h0, "enable stop");
      $display("test jog primary done");
   endtask
   task t_jog_sec;
      wb(1'h1, `SODEL_ADR_CTRL, 32'h1);
      i_field.put(7'h48);
      settle;
      chk1(out_primary, 1'h1, "primary by enable");
      chk1(out_secondary, 1'h0, "secondary no jog");
      i_field.put(7'h4C);
      settle;
      chk1(out_secondary, 1'h1, "secondary on");
      i_field.put(7'h44);
      settle;
      chk1(out_primary, 1'h0, "primary off, jog run");
      chk1(out_secondary, 1'h0, "secondary off");
      $display("test jog secondary done");
   endtask
   task t_cancel;
      i_field.put(7'h40);
      settle;
      i_field.put(7'h00);
      settle;
      chk1(out_delayed, 1'h1, "delay running");
      i_field.put(7'h40);
      repeat (8) @(posedge mclk);
      @(negedge mclk);
      chk1(out_delayed, 1'h1, "guard back in run");
      i_field.put(7'h00);
      repeat (12) @(posedge mclk);
      i_field.put(7'h20);
      settle;
      chk1(out_delayed, 1'h0, "cancel");
      i_field.put(7'h40);
      settle;
      $display("test cancel done");
   endtask
   task t_handover;
      i_field.put(7'h44);
      i_field.put(7'h54);
      i_field.put(7'h44);
      settle;
      chk1(out_primary, 1'h1, "handover");
      $display("test handover done");
   endtask
   task t_timeout;
      wb(1'h1, `SODEL_ADR_MASK, 32'h1);
      i_field.put(7'h4C);
      settle;
      i_field.put(7'h1C);
      i_field.put(7'h0C);
      settle;
      chk1(out_delayed, 1'h1, "latch during delay");
      for (n = 0; n < 2000 && out_delayed !== 1'h0; n++) @(negedge mclk);
      chk1(out_delayed, 1'h0, "delay end");
      settle;
      chk1(irq, 1'h1, "irq raised");
      wb(1'h1, `SODEL_ADR_IRQ, 32'h1);
      settle;
      chk1(irq, 1'h0, "irq cleared");
      for (n = 0; n < 2000 && out_secondary !== 1'h0; n++) @(negedge mclk);
      chk1(out_secondary, 1'h0, "enable timeout");
      repeat (20) @(posedge mclk);
      @(negedge mclk);
      chk1(out_secondary, 1'h0, "held run stays off");
      i_field.cycle_enable(7'h0C);
      settle;
      chk1(out_secondary, 1'h1, "re-armed");
      $display("test timeout done");
   endtask
   initial begin
      #500_000;
      fails++;
      summarize;
   end
   initial begin
      repeat (16) @(posedge mclk);
      srst <= 1'h0;
      t_regs;
      t_jog_pri;
      t_jog_sec;
      t_cancel;
      t_freeze;
      t_handover;
      t_lamps;
      t_timeout;
      summarize;
   end
endmodule // test_sodel_top
